// >>> inc/sensor_ctrl_pkg.sv
/*
  Shared constants and carrier types for the power-down, status and command
  register group of the tilt sensor.
  Assumes a single 125 MHz system clock and a 16-bit serial frame.
*/
// Operation
// - Power-down time is low byte of duration register times half a second.
// - Zero keeps running; non-zero powers down at next data output update.
// - Duration register clears at power-up and on leaving power-down.
// - Power-down ends only on timeout, hardware reset or power cycling; the code also ends it on a software reset command.
// - After power-down, wait about 2 ms before the next conversion.
// - Entering power-down clears new-data flags and forces data-ready inactive.
// - Pending alarm or error shows in bit 14 of every data output register.
// - Status bit 9 is alarm 2, bit 8 is alarm 1.
// - Status bits 3..0: comm failure, update failure, supply high, supply low.
// - Reading the status register clears all its flags.
// - Flags are set again every cycle while their condition lasts.
// - Commands start by writing one to their bit; bits are not kept.
// - Command bit 7 resets the whole device.
// - Command bit 3 stores nonvolatile registers to flash.
// - Command bit 2 latches the auxiliary DAC value; output changes only then.
// - Command bit 1 sets offsets to 000h, scales to 800h, clears filter.
// - Factory reset then stores nonvolatile registers to flash.
// - Command bit 0 nulls X/Y offsets, then stores to flash.
// - A flash store takes up to 50 ms.

`default_nettype none

package sensor_ctrl_pkg;

  // ==========================================================================
  // Timing
  localparam int unsigned CLK_HZ = 125_000_000;
  localparam int unsigned PD_STEP_MS = 500;
  localparam int unsigned PD_STEP_CYCLES = CLK_HZ / 1000 * PD_STEP_MS;
  localparam int unsigned RECOVERY_US = 2000;
  localparam int unsigned RECOVERY_CYCLES = CLK_HZ / 1_000_000 * RECOVERY_US;
  localparam int unsigned FLASH_MS = 50;
  localparam int unsigned FLASH_CYCLES = CLK_HZ / 1000 * FLASH_MS;

  // ==========================================================================
  // Serial frame
  localparam logic [4:0] FRAME_BITS = 5'h10;
  localparam logic [4:0] BITCNT_MAX = 5'h1f;
  localparam int WR_BIT = 15;
  localparam int ADDR_HI = 13;
  localparam int ADDR_LO = 8;

  // ==========================================================================
  // Register byte addresses and reset values
  localparam logic [5:0] ADDR_PD_LO = 6'h3a;
  localparam logic [5:0] ADDR_STATUS = 6'h3c;
  localparam logic [5:0] ADDR_CMD = 6'h3e;
  localparam logic [15:0] PD_RESET = 16'h0000;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  // ==========================================================================
  // Status field positions
  localparam int ST_ALARM2 = 9;
  localparam int ST_ALARM1 = 8;
  localparam int ST_COMM_ERR = 3;
  localparam int ST_UPDATE_ERR = 2;
  localparam int ST_SUPPLY_HIGH = 1;
  localparam int ST_SUPPLY_LOW = 0;
  localparam int DATA_PENDING_BIT = 14;

  // ==========================================================================
  // Command bit positions
  localparam int CMD_SW_RESET = 7;
  localparam int CMD_FLASH_STORE = 3;
  localparam int CMD_DAC_LATCH = 2;
  localparam int CMD_FACTORY = 1;
  localparam int CMD_NULL = 0;

  // Factory calibration defaults applied by the consumer of factory_reset
  localparam logic [11:0] OFFSET_DEFAULT = 12'h000;
  localparam logic [11:0] SCALE_DEFAULT = 12'h800;

  // ==========================================================================
  // Carriers
  typedef struct packed {
    logic alarm2;
    logic alarm1;
    logic update_fail;
    logic supply_high;
    logic supply_low;
  } status_cond_t;

  typedef struct packed {
    logic sw_reset;
    logic flash_store;
    logic dac_latch;
    logic factory_reset;
    logic null_offsets;
  } cmd_pulse_t;

  typedef enum logic [2:0] {
    PS_RUN = 3'b001,
    PS_DOWN = 3'b010,
    PS_RECOVER = 3'b100
  } pwr_state_t;

endpackage

`default_nettype wire

// >>> hw/sync_stage2.sv
/*
  Two-flop synchroniser for a vector of independent levels.
  Assumes each bit is a slow level; no bus coherence across bits.
*/
`default_nettype none

module sync_stage2 #(
  parameter int W = 1
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic [W-1:0] init_i,
  // Data
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_reg;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      meta_reg <= init_i;
      q_o <= init_i;
    end else begin
      meta_reg <= d_i;
      q_o <= meta_reg;
    end
  end

endmodule

`default_nettype wire

// >>> hw/sensor_power_status_command_regs.sv
/*
  Power-down timer, clear-on-read status and write-only command register,
  reached over a 16-bit serial slave port (clock idles high, data sampled on
  the rising clock edge).
  Assumes the serial pins are asynchronous to mclk_i and that the serial
  clock is at least four times slower than mclk_i.
  Limitation: a cut frame only raises the comm flag; nothing else acts.
  The serial port stays live during power-down and recovery.
*/
`default_nettype none

module sensor_power_status_command_regs
  import sensor_ctrl_pkg::*;
#(
  parameter int unsigned PD_STEP_CYC = PD_STEP_CYCLES,
  parameter int unsigned RECOVERY_CYC = RECOVERY_CYCLES,
  parameter int unsigned FLASH_CYC = FLASH_CYCLES,
  parameter int DAC_W = 12
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Serial port
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  output logic miso_o,
  output logic miso_oe_o,
  // Alarm and error conditions
  input wire status_cond_t cond_i,
  // Conversion side
  input wire logic data_update_i,
  input wire logic data_ready_i,
  output logic data_ready_o,
  output logic new_data_clear_o,
  output logic flag_pending_o,
  output logic powered_down_o,
  output logic recovering_o,
  // Commands
  output cmd_pulse_t cmd_o,
  output logic flash_busy_o,
  // Auxiliary DAC
  input wire logic [DAC_W-1:0] dac_value_i,
  output logic [DAC_W-1:0] dac_out_o
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic sclk_d;
    logic csn_d;
    logic [4:0] bit_cnt;
    logic [15:0] shift_in;
    logic [15:0] shift_out;
    logic [15:0] rd_word;
    logic miso;
    logic miso_oe;
    logic [7:0] pd_dur;
    logic [15:0] status;
    pwr_state_t pwr;
    logic [7:0] remaining;
    logic [31:0] pd_cnt;
    logic [31:0] flash_cnt;
    logic flash_busy;
    logic flash_pend;
    cmd_pulse_t cmd;
    logic [DAC_W-1:0] dac_out;
    logic data_ready;
    logic nd_clear;
    logic flag_pending;
    logic pwr_down;
    logic pwr_rec;
  } state_t;

  // Pins reset to their idle levels so no false edge follows reset
  localparam logic SCLK_IDLE = 1'b1;
  localparam logic CSN_IDLE = 1'b1;
  localparam logic MOSI_IDLE = 1'b0;
  localparam logic [2:0] PIN_IDLE = {SCLK_IDLE, CSN_IDLE, MOSI_IDLE};

  // Duration codes seen by the power-down sequencer
  localparam logic [7:0] PD_OFF = 8'h00;
  localparam logic [7:0] PD_LAST = 8'h01;

  localparam state_t ST_RESET = '{
    default: '0,
    sclk_d: SCLK_IDLE,
    csn_d: CSN_IDLE,
    pd_dur: PD_RESET[7:0],
    status: STATUS_RESET,
    pwr: PS_RUN
  };

  state_t st_reg;
  state_t st_next;

  // ==========================================================================
  // Pin synchronisation
  logic [2:0] pins_s;
  logic sclk_s;
  logic csn_s;
  logic mosi_s;

  sync_stage2 #(
    .W(3)
  ) u_pin_sync (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .init_i(PIN_IDLE),
    .d_i({sclk_i, cs_n_i, mosi_i}),
    .q_o(pins_s)
  );

  assign sclk_s = pins_s[2];
  assign csn_s = pins_s[1];
  assign mosi_s = pins_s[0];

  // ==========================================================================
  // Next-state logic
  logic sclk_rise;
  logic cs_fall;
  logic cs_rise;
  logic sw_rst;
  logic [15:0] events;
  logic [15:0] clr;
  logic [15:0] flag_mask;
  logic [5:0] addr;
  logic [7:0] wdata;
  logic [4:0] word_addr;
  logic frame_ok;
  logic frame_wr;
  logic step_en;
  logic rec_en;
  logic flash_en;

  always_comb begin
    st_next = st_reg;
    sw_rst = 1'b0;
    events = '0;
    clr = '0;
    flag_mask = '0;
    addr = st_reg.shift_in[ADDR_HI:ADDR_LO];
    wdata = st_reg.shift_in[7:0];

    // Reads decode the word address; either byte address returns the whole word
    word_addr = addr[5:1];
    frame_ok = (st_reg.bit_cnt == FRAME_BITS);
    frame_wr = st_reg.shift_in[WR_BIT];

    // Divider terminal counts act as one-cycle enables
    step_en = (st_reg.pd_cnt == PD_STEP_CYC - 1);
    rec_en = (st_reg.pd_cnt == RECOVERY_CYC - 1);
    flash_en = (st_reg.flash_cnt == FLASH_CYC - 1);

    // Edge detectors start at the idle levels of their pins
    st_next.cmd = '0;
    st_next.nd_clear = 1'b0;
    st_next.sclk_d = sclk_s;
    st_next.csn_d = csn_s;
    sclk_rise = sclk_s & ~st_reg.sclk_d;
    cs_fall = ~csn_s & st_reg.csn_d;
    cs_rise = csn_s & ~st_reg.csn_d;

    // Conditions are sampled every cycle so a lasting one re-sets its flag
    events[ST_ALARM2] = cond_i.alarm2;
    events[ST_ALARM1] = cond_i.alarm1;
    events[ST_UPDATE_ERR] = cond_i.update_fail;
    events[ST_SUPPLY_HIGH] = cond_i.supply_high;
    events[ST_SUPPLY_LOW] = cond_i.supply_low;
    flag_mask[ST_ALARM2] = 1'b1;
    flag_mask[ST_ALARM1] = 1'b1;
    flag_mask[ST_COMM_ERR] = 1'b1;
    flag_mask[ST_UPDATE_ERR] = 1'b1;
    flag_mask[ST_SUPPLY_HIGH] = 1'b1;
    flag_mask[ST_SUPPLY_LOW] = 1'b1;

    // ========================================================================
    // Flash store sequencing
    if (st_reg.flash_pend) begin
      // Issued one cycle after the command so defaults/null land first
      st_next.flash_pend = 1'b0;
      st_next.cmd.flash_store = 1'b1;
      st_next.flash_busy = 1'b1;
      st_next.flash_cnt = '0;
    end else if (st_reg.flash_busy) begin
      if (flash_en) begin
        st_next.flash_busy = 1'b0;
      end else begin
        st_next.flash_cnt = st_reg.flash_cnt + 32'h1;
      end
    end

    // ========================================================================
    // Serial shifter
    if (cs_fall) begin
      // Answer of the previous read frame goes out now
      st_next.bit_cnt = '0;
      st_next.shift_out = st_reg.rd_word;
      st_next.miso = st_reg.rd_word[15];
      st_next.miso_oe = 1'b1;
    end else if (!csn_s && sclk_rise) begin
      // Next bit moves out right after the master has sampled this one
      st_next.shift_in = {st_reg.shift_in[14:0], mosi_s};
      st_next.shift_out = {st_reg.shift_out[14:0], 1'b0};
      st_next.miso = st_reg.shift_out[14];
      if (st_reg.bit_cnt != BITCNT_MAX) begin
        st_next.bit_cnt = st_reg.bit_cnt + 5'h1;
      end
    end

    // ========================================================================
    // Frame decode at chip-select release
    // Acting only on select release means a cut frame never acts
    if (cs_rise) begin
      // Line parked low while deselected; the enable tells the pad
      st_next.miso_oe = 1'b0;
      st_next.miso = 1'b0;
      if (!frame_ok) begin
        // Short or long frame is dropped and reported
        events[ST_COMM_ERR] = 1'b1;
      end else if (frame_wr) begin
        st_next.rd_word = '0;
        // Status and odd bytes take no write
        if (addr == ADDR_PD_LO) begin
          st_next.pd_dur = wdata;
        end
        // Command bits act once and are never stored
        if (addr == ADDR_CMD) begin
          if (wdata[CMD_DAC_LATCH]) begin
            st_next.dac_out = dac_value_i;
            st_next.cmd.dac_latch = 1'b1;
          end
          if (wdata[CMD_FACTORY]) begin
            st_next.cmd.factory_reset = 1'b1;
            st_next.flash_pend = 1'b1;
          end
          if (wdata[CMD_NULL]) begin
            st_next.cmd.null_offsets = 1'b1;
            st_next.flash_pend = 1'b1;
          end
          if (wdata[CMD_FLASH_STORE]) begin
            st_next.flash_pend = 1'b1;
          end
          sw_rst = wdata[CMD_SW_RESET];
        end
      end else begin
        case (word_addr)
          ADDR_PD_LO[5:1]: st_next.rd_word = {8'h00, st_reg.pd_dur};
          ADDR_STATUS[5:1]: begin
            st_next.rd_word = st_reg.status;
            clr = flag_mask;
          end
          default: st_next.rd_word = '0;
        endcase
      end
    end

    // Set wins over the clear of the same read
    st_next.status = ((st_reg.status & ~clr) | events) & flag_mask;

    // ========================================================================
    // Power-down sequencer
    case (st_reg.pwr)
      PS_RUN: begin
        if (st_reg.pd_dur != PD_OFF && data_update_i) begin
          st_next.pwr = PS_DOWN;
          st_next.remaining = st_reg.pd_dur;
          st_next.pd_dur = PD_OFF;
          st_next.pd_cnt = '0;
          st_next.nd_clear = 1'b1;
        end
      end
      PS_DOWN: begin
        // Only the last half-second step, reset_i or a software reset command leaves this state
        if (step_en) begin
          st_next.pd_cnt = '0;
          if (st_reg.remaining == PD_LAST) begin
            st_next.pwr = PS_RECOVER;
            st_next.pd_dur = PD_OFF;
          end else begin
            st_next.remaining = st_reg.remaining - PD_LAST;
          end
        end else begin
          st_next.pd_cnt = st_reg.pd_cnt + 32'h1;
        end
      end
      PS_RECOVER: begin
        // Conversions stay blocked until the converter has settled
        if (rec_en) begin
          st_next.pwr = PS_RUN;
          st_next.pd_cnt = '0;
        end else begin
          st_next.pd_cnt = st_reg.pd_cnt + 32'h1;
        end
      end
      default: begin
        st_next.pwr = PS_RUN;
        st_next.pd_cnt = '0;
      end
    endcase

    // Data-ready is held low from power-down until recovery ends
    st_next.data_ready = data_ready_i && (st_next.pwr == PS_RUN);
    st_next.flag_pending = |st_next.status;

    // Software reset restarts everything but still reports itself
    if (sw_rst) begin
      st_next = ST_RESET;
      st_next.cmd.sw_reset = 1'b1;
    end

    // Level outputs decoded here so each port leaves a flip-flop
    st_next.pwr_down = (st_next.pwr == PS_DOWN);
    st_next.pwr_rec = (st_next.pwr == PS_RECOVER);
  end

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_reg <= ST_RESET;
    end else begin
      st_reg <= st_next;
    end
  end

  // ==========================================================================
  // Outputs
  assign miso_o = st_reg.miso;
  assign miso_oe_o = st_reg.miso_oe;
  assign data_ready_o = st_reg.data_ready;
  assign new_data_clear_o = st_reg.nd_clear;
  assign flag_pending_o = st_reg.flag_pending;
  assign powered_down_o = st_reg.pwr_down;
  assign recovering_o = st_reg.pwr_rec;
  assign cmd_o = st_reg.cmd;
  assign flash_busy_o = st_reg.flash_busy;
  assign dac_out_o = st_reg.dac_out;

endmodule

`default_nettype wire

// >>> dv/sensor_regs_chk.sv
/* Port checker for the power, status and command register group.
   Bound to the top module; sees only its ports. */
`default_nettype none
module sensor_regs_chk
  import sensor_ctrl_pkg::*;
#(
  parameter int unsigned PD_STEP_CYC = 1,
  parameter int unsigned RECOVERY_CYC = 1,
  parameter int unsigned FLASH_CYC = 1,
  parameter int DAC_W = 12
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic reset_i,
  // Serial port
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic mosi_i,
  input wire logic miso_o,
  input wire logic miso_oe_o,
  // Conditions and conversion side
  input wire status_cond_t cond_i,
  input wire logic data_update_i,
  input wire logic data_ready_i,
  input wire logic data_ready_o,
  input wire logic new_data_clear_o,
  input wire logic flag_pending_o,
  input wire logic powered_down_o,
  input wire logic recovering_o,
  // Commands and DAC
  input wire cmd_pulse_t cmd_o,
  input wire logic flash_busy_o,
  input wire logic [DAC_W-1:0] dac_value_i,
  input wire logic [DAC_W-1:0] dac_out_o
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  logic [31:0] rec_cnt_reg;
  // ==========================================
  // Recovery length counter
  always_ff @(posedge mclk_i) begin
    if (reset_i || !recovering_o) rec_cnt_reg <= '0;
    else rec_cnt_reg <= rec_cnt_reg + 32'h1;
  end
  // ==========================================
  // Assertions
  a_recover_len: assert property ($fell(recovering_o) |-> rec_cnt_reg == RECOVERY_CYC)
    else $error("recovery length wrong");
  a_factory_store: assert property (cmd_o.factory_reset |=> cmd_o.flash_store)
    else $error("factory reset without flash store");
  a_null_store: assert property (cmd_o.null_offsets |=> cmd_o.flash_store)
    else $error("null without flash store");
  a_store_busy: assert property (cmd_o.flash_store |=> flash_busy_o)
    else $error("flash store without busy");
  a_latch_single: assert property (cmd_o.dac_latch |=> !cmd_o.dac_latch)
    else $error("command pulse held");
  a_dac_latch_only: assert property ($changed(dac_out_o) |-> cmd_o.dac_latch ||
    $past(cmd_o.dac_latch) || cmd_o.sw_reset || $past(cmd_o.sw_reset))
    else $error("dac output moved without latch");
  a_ready_quiet: assert property (powered_down_o && $past(powered_down_o) |-> !data_ready_o)
    else $error("data ready active in power-down");
  a_clear_entry: assert property (new_data_clear_o |-> ##[0:1] powered_down_o)
    else $error("new data clear outside power-down entry");
  a_entry_update: assert property ($rose(powered_down_o) |-> $past(data_update_i) ||
    $past(data_update_i, 2) || $past(data_update_i, 3))
    else $error("power-down without data update");
  a_flag_follow: assert property ((|cond_i) |-> ##[1:2] flag_pending_o)
    else $error("pending flag not set by condition");
  a_oe_select: assert property ($fell(cs_n_i) |-> ##[1:4] miso_oe_o)
    else $error("data out not enabled after select");
  a_oe_release: assert property ($rose(cs_n_i) |-> ##[1:4] !miso_oe_o)
    else $error("data out still enabled after release");
endmodule
bind sensor_power_status_command_regs sensor_regs_chk #(.PD_STEP_CYC(PD_STEP_CYC),
  .RECOVERY_CYC(RECOVERY_CYC), .FLASH_CYC(FLASH_CYC), .DAC_W(DAC_W)) sensor_regs_chk_inst (
  .mclk_i(mclk_i), .reset_i(reset_i), .sclk_i(sclk_i), .cs_n_i(cs_n_i), .mosi_i(mosi_i),
  .miso_o(miso_o), .miso_oe_o(miso_oe_o), .cond_i(cond_i), .data_update_i(data_update_i),
  .data_ready_i(data_ready_i), .data_ready_o(data_ready_o),
  .new_data_clear_o(new_data_clear_o), .flag_pending_o(flag_pending_o),
  .powered_down_o(powered_down_o), .recovering_o(recovering_o), .cmd_o(cmd_o),
  .flash_busy_o(flash_busy_o), .dac_value_i(dac_value_i), .dac_out_o(dac_out_o));
`default_nettype wire

// >>> dv/spi_host_model.sv
/* Host serial master: 16-bit MSB-first frames, clock idles high.
   Assumes the caller waits between frames as it likes. */
`default_nettype none
module spi_host_model (
  // Clock
  input wire logic mclk_i,
  // Serial port
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sclk_o = 1'b1;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // Short counts make a malformed frame
  task automatic frame(input logic [15:0] w, input int nbits, output logic [15:0] r);
    r = '0;
    @(posedge mclk_i);
    #1;
    cs_n_o = 1'b0;
    #62.5;
    for (int i = 0; i < nbits; i++) begin
      sclk_o = 1'b0;
      mosi_o = w[15 - i];
      #62.5;
      r = {r[14:0], miso_i};
      sclk_o = 1'b1;
      #62.5;
    end
    cs_n_o = 1'b1;
    // Released line must not show the last bit
    mosi_o = ~mosi_o;
    #100;
  endtask
endmodule
`default_nettype wire

// >>> dv/sensor_power_status_command_regs_tb.sv
/* Self-checking bench for the register group, host model on the serial port.
   Short step, recovery and flash counts keep the run brief. */
`default_nettype none
module sensor_power_status_command_regs_tb;
  import sensor_ctrl_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  localparam int unsigned PDS = 50;
  localparam int unsigned RCV = 20;
  localparam int unsigned FLS = 30;
  logic mclk_i = 1'b0;
  logic reset_i = 1'b1;
  logic upd = 1'b0;
  logic rdy_i = 1'b1;
  logic sclk, cs_n, mosi, miso, miso_oe, rdy_o, ndc, pend, down, rec, busy;
  logic [2:0] lv;
  status_cond_t cond = '0;
  cmd_pulse_t cmd;
  logic [11:0] dacv = 12'h000;
  logic [11:0] daco;
  logic [15:0] pcnt [5];
  logic [15:0] run [3];
  logic [15:0] last [3];
  logic [15:0] ndcs;
  int fails = 0;
  int n_tests = 0;
  always #4 mclk_i = ~mclk_i;
  assign lv = {rec, down, busy};
  sensor_power_status_command_regs #(.PD_STEP_CYC(PDS), .RECOVERY_CYC(RCV), .FLASH_CYC(FLS),
    .DAC_W(12)) sensor_power_status_command_regs_inst (.mclk_i(mclk_i), .reset_i(reset_i),
    .sclk_i(sclk), .cs_n_i(cs_n), .mosi_i(mosi), .miso_o(miso), .miso_oe_o(miso_oe),
    .cond_i(cond), .data_update_i(upd), .data_ready_i(rdy_i), .data_ready_o(rdy_o),
    .new_data_clear_o(ndc), .flag_pending_o(pend), .powered_down_o(down),
    .recovering_o(rec), .cmd_o(cmd), .flash_busy_o(busy), .dac_value_i(dacv),
    .dac_out_o(daco));
  spi_host_model spi_host_model_inst (.mclk_i(mclk_i), .sclk_o(sclk), .cs_n_o(cs_n),
    .mosi_o(mosi), .miso_i(miso));
  // ==========================================
  // Pulse counts and level run lengths
  always @(posedge mclk_i) begin
    for (int k = 0; k < 5; k++) if (cmd[k]) pcnt[k]++;
    if (ndc) ndcs++;
    for (int k = 0; k < 3; k++) begin
      if (lv[k]) run[k]++;
      else begin
        if (run[k] != 0) last[k] = run[k];
        run[k] = '0;
      end
    end
  end
  // ==========================================
  // Helpers
  task automatic tick(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask
  task automatic clr();
    foreach (pcnt[k]) pcnt[k] = '0;
    foreach (run[k]) run[k] = '0;
    foreach (last[k]) last[k] = '0;
    ndcs = '0;
  endtask
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [7:0] v);
    logic [15:0] r;
    spi_host_model_inst.frame({2'b10, a, v}, 16, r);
  endtask
  // Read answer arrives in the following frame
  task automatic rc(input string nm, input logic [5:0] a, input logic [15:0] exp);
    logic [15:0] r;
    spi_host_model_inst.frame({2'b00, a, 8'h00}, 16, r);
    spi_host_model_inst.frame(16'h3e00, 16, r);
    chk(nm, exp, r);
  endtask
  task automatic report_and_stop();
    if (fails == 0 && n_tests > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_status();
    logic [3:0] pos [5] = '{4'h9, 4'h8, 4'h2, 4'h1, 4'h0};
    logic [15:0] r;
    for (int i = 0; i < 5; i++) begin
      cond = 5'h10 >> i;
      tick(3);
      chk("pending", 16'h1, {15'h0, pend});
      cond = '0;
      rc("flag", 6'h3c, 16'h1 << pos[i]);
      rc("cleared", 6'h3c, 16'h0);
    end
    cond.alarm1 = 1'b1;
    rc("held", 6'h3c, 16'h0100);
    rc("set_wins", 6'h3c, 16'h0100);
    cond = '0;
    rc("last", 6'h3c, 16'h0100);
    chk("pend_off", 16'h0, {15'h0, pend});
    spi_host_model_inst.frame(16'h3c00, 15, r);
    rc("comm_err", 6'h3c, 16'h0008);
  endtask
  // One-cycle condition exactly on the decode edge of a clearing read
  task automatic t_set_wins();
    logic [15:0] r;
    fork
      spi_host_model_inst.frame(16'h3c00, 16, r);
      begin
        @(posedge mclk_i);
        repeat (259) @(posedge mclk_i);
        #1;
        cond.alarm2 = 1'b1;
        @(posedge mclk_i);
        #1;
        cond.alarm2 = 1'b0;
      end
    join
    spi_host_model_inst.frame(16'h3e00, 16, r);
    chk("pre_pulse", 16'h0, r);
    rc("kept", 6'h3c, 16'h0200);
  endtask
  task automatic t_cmd();
    logic [7:0] code [4] = '{8'h08, 8'h04, 8'h02, 8'h01};
    logic [15:0] fl [4] = '{16'h1, 16'h0, 16'h1, 16'h1};
    dacv = 12'h5a3;
    for (int i = 0; i < 4; i++) begin
      clr();
      wr(6'h3e, code[i]);
      tick(FLS + 10);
      chk("own_pulse", 16'h1, pcnt[3 - i]);
      chk("flash", fl[i], pcnt[3]);
      if (fl[i] != 0) chk("busy_len", 16'(FLS), last[0]);
      chk("dac", (i >= 1) ? 16'h05a3 : 16'h0000, {4'h0, daco});
      if (i == 1) dacv = 12'h3c1;
    end
    rc("cmd_read", 6'h3e, 16'h0);
    wr(6'h3a, 8'h05);
    clr();
    wr(6'h3e, 8'h80);
    tick(5);
    chk("sw_pulse", 16'h1, pcnt[4]);
    chk("dac_rst", 16'h0, {4'h0, daco});
    rc("pd_rst", 6'h3a, 16'h0);
  endtask
  task automatic t_power();
    wr(6'h3b, 8'hff);
    wr(6'h3a, 8'h03);
    rc("pd_val", 6'h3a, 16'h0003);
    chk("no_down", 16'h0, {15'h0, down});
    clr();
    upd = 1'b1;
    tick(1);
    upd = 1'b0;
    tick(3);
    chk("down", 16'h1, {15'h0, down});
    chk("rdy_off", 16'h0, {15'h0, rdy_o});
    chk("nd_clear", 16'h1, ndcs);
    tick(3 * PDS + RCV + 10);
    chk("down_len", 16'(3 * PDS), last[1]);
    chk("rec_len", 16'(RCV), last[2]);
    rc("pd_zero", 6'h3a, 16'h0);
    upd = 1'b1;
    tick(1);
    upd = 1'b0;
    tick(3);
    chk("stay_up", 16'h0, {15'h0, down});
    chk("rdy_on", 16'h1, {15'h0, rdy_o});
  endtask
  // ==========================================
  // Main sequence and watchdog
  initial begin
    clr();
    tick(4);
    reset_i = 1'b0;
    tick(5);
    rc("pd_init", 6'h3a, 16'h0);
    rc("st_init", 6'h3c, 16'h0);
    t_status();
    t_set_wins();
    t_cmd();
    t_power();
    report_and_stop();
  end
  // About fifty-three frames of some 270 cycles each, with ample margin
  initial begin
    repeat (60000) @(posedge mclk_i);
    fails++;
    report_and_stop();
  end
endmodule
`default_nettype wire
